/* core/vrms_power_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes a 125 MHz core clock and an 8 kHz sample strobe from the adc side
`ifndef VRMS_POWER_REGS_SVH
`define VRMS_POWER_REGS_SVH
`define REG_VAVG_A       8'h00
`define REG_VAVG_B       8'h01
`define REG_VAVG_C       8'h02
`define REG_VOFS_A       8'h08
`define REG_VOFS_B       8'h09
`define REG_VOFS_C       8'h0a
`define REG_WATT_A       8'h10
`define REG_WATT_B       8'h11
`define REG_WATT_C       8'h12
`define REG_VRMS_A       8'h18
`define REG_VRMS_B       8'h19
`define REG_VRMS_C       8'h1a
`define REG_ACCUMULATION_MODE_REGISTER      8'h20
`define REG_CONFIG       8'h21
`define WIRING_CONFIG_SELECT_LSB       0
`define WIRING_CONFIG_SELECT_DELTA     2'h1
`define POWER_FILTER_STRENGTH_SELECT_BIT       1
`define ACCUMULATION_MODE_REGISTER_RST      2'h0
`define POWER_FILTER_STRENGTH_SELECT_RST       1'b0
`define OFS_RST          24'h000000
`define OFS_SCALE_SHIFT  7
`define WATT_SHIFT       23
`define SAMPLE_RATE_HZ   64'd8000
`define LRIP_PERIOD_US   64'd1024000
`define LRIP_SAMPLES     ((`LRIP_PERIOD_US * `SAMPLE_RATE_HZ) / 64'd1000000)
`define LRIP_SHIFT       13
`define LRIP_LAST        13'(`LRIP_SAMPLES - 64'd1)
`define LPF_SETTLE_MS    650
`define LPF_SETTLE2_MS   1300
`define MS_SHIFT_DEF     8
`define LPF_SHIFT_DEF    10
`define SQ_RAD_W         50
`define SQ_ROOT_W        25
`endif

/* core/vrms_power_pkg.sv */
// types shared by the rms and active power datapath
// widths come from the register header
package vrms_power_pkg;
`include "vrms_power_regs.svh"

   typedef struct packed {
      logic [2:0][23:0] volt;
      logic [2:0][23:0] curr;
   } sample_t;

   typedef struct packed {
      logic        wr_en;
      logic        rd_en;
      logic [7:0]  addr;
      logic [31:0] wr_data;
   } reg_req_t;

   typedef struct packed {
      logic        rd_valid;
      logic [31:0] rd_data;
   } reg_rsp_t;

   typedef enum logic [1:0] {seq_idle_e, seq_root_e, seq_wait_e} seq_t;

   typedef struct packed {
      seq_t                            seq;
      logic [1:0]                      ph;
      logic [2:0][`SQ_RAD_W-1:0]       ms;
      logic [2:0][47:0]                pf1;
      logic [2:0][47:0]                pf2;
      logic [2:0][23:0]                rms;
      logic [2:0][23:0]                watt;
      logic [2:0][23:0]                offs;
      logic [2:0][23:0]                lrip;
      logic [2:0][23+`LRIP_SHIFT:0]    lacc;
      logic [`LRIP_SHIFT-1:0]          lcnt;
      logic [1:0]                      wiring_config_select;
      logic                            power_filter_strength_select;
      logic                            upd;
      logic                            rd_valid;
      logic [31:0]                     rd_data;
   } main_state_t;
endpackage

/* core/isqrt_seq.sv */
// bit-serial integer square root, one result bit per clock
// assumes start is a one-cycle pulse and rad is stable in that cycle
`timescale 1ns/1ps
module isqrt_seq #(
   parameter int RW = 50,
   parameter int QW = 25
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          start,
   input  wire logic [RW-1:0] rad,
   output logic               done,
   output logic [QW-1:0]      root
);
   typedef struct packed {
      logic          busy;
      logic          done;
      logic [5:0]    cnt;
      logic [RW-1:0] x;
      logic [RW-1:0] res;
      logic [RW-1:0] bv;
      logic [RW-1:0] hold;
   } sq_state_t;

   sq_state_t s_ff, nxt_s;
   logic [RW-1:0] trial;

   assign trial = s_ff.res + s_ff.bv;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      if (start) begin
         nxt_s.busy = 1'b1;
         nxt_s.cnt  = 6'h00;
         nxt_s.x    = rad;
         nxt_s.hold = rad;
         nxt_s.res  = '0;
         nxt_s.bv   = {2'b01, {(RW-2){1'b0}}};
      end else if (s_ff.busy) begin
         if (s_ff.x >= trial) begin
            nxt_s.x   = s_ff.x - trial;
            nxt_s.res = (s_ff.res >> 1) + s_ff.bv;
         end else begin
            nxt_s.res = s_ff.res >> 1;
         end
         nxt_s.bv  = s_ff.bv >> 2;
         nxt_s.cnt = s_ff.cnt + 6'h01;
         if (s_ff.cnt == 6'(QW-1)) begin
            nxt_s.busy = 1'b0;
            nxt_s.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) s_ff <= '0;
      else        s_ff <= nxt_s;
   end

   assign done = s_ff.done;
   assign root = s_ff.res[QW-1:0];

   // helper squares, wide enough that root+1 cannot wrap
   logic [2*QW+1:0] lo_sq, hi_sq;
   assign lo_sq = (2*QW+2)'(root) * (2*QW+2)'(root);
   assign hi_sq = ((2*QW+2)'(root) + 1'b1) * ((2*QW+2)'(root) + 1'b1);

   root_exact_a: assert property (@(posedge clk) disable iff (!rst_n)
      done |-> (lo_sq <= (2*QW+2)'(s_ff.hold)) && (hi_sq > (2*QW+2)'(s_ff.hold)))
      else $error("square root result off");

   root_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
      start |-> ##[1:30] done)
      else $error("square root did not finish in time");
endmodule

/* core/voltage_rms_active_power_dsp.sv */
// three-phase voltage rms, low-ripple rms averages and per-phase active power
// assumes one sample set per samp_valid at 8 kHz, on clk, from the adc side;
// the serial port front end delivers decoded register word accesses
`timescale 1ns/1ps
`include "vrms_power_regs.svh"

module voltage_rms_active_power_dsp
   import vrms_power_pkg::*;
#(
   parameter int MS_SHIFT  = `MS_SHIFT_DEF,
   parameter int LPF_SHIFT = `LPF_SHIFT_DEF,
   // rms sets per average are 2**AVG_LOG2; at most 13, the counter width
   parameter int AVG_LOG2  = `LRIP_SHIFT
) (
   input  wire logic     clk,
   input  wire logic     rst_n,
   input  wire sample_t  samp,
   input  wire logic     samp_valid,
   output logic          samp_ready,
   input  wire reg_req_t reg_req,
   output reg_rsp_t      reg_rsp,
   output logic          rms_update
);
   localparam int RW = `SQ_RAD_W;
   localparam int QW = `SQ_ROOT_W;
   localparam logic [`LRIP_SHIFT-1:0] AVG_LAST = (`LRIP_SHIFT)'((1 << AVG_LOG2) - 1);

   main_state_t s_ff, nxt_s;

   logic                  delta;
   logic [2:0][RW-1:0]    sq;
   logic [2:0][47:0]      pw;
   logic signed [RW+1:0]  rad_c;
   logic [RW-1:0]         rad;
   logic                  sq_start;
   logic                  sq_done;
   logic [QW-1:0]         sq_root;
   logic [23:0]           root_sat;
   logic                  samp_take;
   logic                  avg_end;

   assign delta = (s_ff.wiring_config_select == `WIRING_CONFIG_SELECT_DELTA);

   // squares and products per phase; the delta b slot sees va - vc
   for (genvar g = 0; g < 3; g++) begin : g_phase
      logic signed [24:0] vsel;
      logic signed [49:0] vv;
      logic signed [47:0] vi;
      if (g == 1) begin : g_b
         assign vsel = delta ? ($signed({samp.volt[0][23], samp.volt[0]})
                              - $signed({samp.volt[2][23], samp.volt[2]}))
                             : $signed({samp.volt[1][23], samp.volt[1]});
      end else begin : g_ac
         assign vsel = $signed({samp.volt[g][23], samp.volt[g]});
      end
      assign vv    = vsel * vsel;
      assign vi    = $signed(samp.volt[g]) * $signed(samp.curr[g]);
      assign sq[g] = RW'(vv);
      assign pw[g] = (g == 1 && delta) ? 48'h0 : vi;
   end

   // offset compensation ahead of the root; b offset also serves delta
   assign rad_c = $signed({2'b00, s_ff.ms[s_ff.ph]})
                + ($signed((RW+2)'($signed(s_ff.offs[s_ff.ph])))
                   <<< `OFS_SCALE_SHIFT);
   // a negative square root is undefined, so feed zero instead
   assign rad      = rad_c[RW+1] ? '0 : rad_c[RW-1:0];
   assign sq_start = (s_ff.seq == seq_root_e);

   isqrt_seq #(
      .RW (RW),
      .QW (QW)
   ) u_sqrt (
      .clk   (clk),
      .rst_n (rst_n),
      .start (sq_start),
      .rad   (rad),
      .done  (sq_done),
      .root  (sq_root)
   );

   // the 25-bit root is clipped to 7fffff only when bit 24 is set; bit 23 passes through
   assign root_sat = sq_root[QW-1] ? 24'h7fffff : sq_root[23:0];

   // a sample is taken only while idle; the last root of a period closes it
   assign samp_take = (s_ff.seq == seq_idle_e) && samp_valid;
   assign avg_end   = (s_ff.seq == seq_wait_e) && sq_done && (s_ff.ph == 2'h2)
                    && (s_ff.lcnt == AVG_LAST);

   always_comb begin
      logic signed [RW+1:0] dms;
      logic signed [48:0]   d1;
      logic signed [48:0]   d2;
      logic [47:0]          pf;
      nxt_s = s_ff;
      dms   = '0;
      d1    = '0;
      d2    = '0;
      pf    = '0;
      nxt_s.upd      = 1'b0;
      nxt_s.rd_valid = 1'b0;

      if (reg_req.wr_en) begin
         unique case (reg_req.addr)
            `REG_VOFS_A:  nxt_s.offs[0] = reg_req.wr_data[23:0];
            `REG_VOFS_B:  nxt_s.offs[1] = reg_req.wr_data[23:0];
            `REG_VOFS_C:  nxt_s.offs[2] = reg_req.wr_data[23:0];
            `REG_ACCUMULATION_MODE_REGISTER: nxt_s.wiring_config_select  = reg_req.wr_data[`WIRING_CONFIG_SELECT_LSB +: 2];
            `REG_CONFIG:  nxt_s.power_filter_strength_select  = reg_req.wr_data[`POWER_FILTER_STRENGTH_SELECT_BIT];
            default:      nxt_s.wiring_config_select  = s_ff.wiring_config_select;
         endcase
      end

      if (reg_req.rd_en) begin
         nxt_s.rd_valid = 1'b1;
         unique case (reg_req.addr)
            `REG_VAVG_A: nxt_s.rd_data = {8'h00, s_ff.lrip[0]};
            `REG_VAVG_B: nxt_s.rd_data = {8'h00, s_ff.lrip[1]};
            `REG_VAVG_C: nxt_s.rd_data = {8'h00, s_ff.lrip[2]};
            `REG_VRMS_A: nxt_s.rd_data = {8'h00, s_ff.rms[0]};
            `REG_VRMS_B: nxt_s.rd_data = {8'h00, s_ff.rms[1]};
            `REG_VRMS_C: nxt_s.rd_data = {8'h00, s_ff.rms[2]};
            `REG_WATT_A: nxt_s.rd_data = {8'h00, s_ff.watt[0]};
            `REG_WATT_B: nxt_s.rd_data = {8'h00, s_ff.watt[1]};
            `REG_WATT_C: nxt_s.rd_data = {8'h00, s_ff.watt[2]};
            `REG_VOFS_A: nxt_s.rd_data = {4'h0, {4{s_ff.offs[0][23]}}, s_ff.offs[0]};
            `REG_VOFS_B: nxt_s.rd_data = {4'h0, {4{s_ff.offs[1][23]}}, s_ff.offs[1]};
            `REG_VOFS_C: nxt_s.rd_data = {4'h0, {4{s_ff.offs[2][23]}}, s_ff.offs[2]};
            `REG_ACCUMULATION_MODE_REGISTER: nxt_s.rd_data = {30'h0, s_ff.wiring_config_select};
            `REG_CONFIG:  nxt_s.rd_data = {30'h0, s_ff.power_filter_strength_select, 1'b0};
            default:      nxt_s.rd_data = 32'h00000000;
         endcase
      end

      unique case (s_ff.seq)
         seq_idle_e: begin
            if (samp_valid) begin
               for (int p = 0; p < 3; p++) begin
                  // mean square of the voltage, one pole
                  dms = $signed({2'b00, sq[p]}) - $signed({2'b00, s_ff.ms[p]});
                  nxt_s.ms[p] = RW'($signed({2'b00, s_ff.ms[p]}) + (dms >>> MS_SHIFT));
                  // two cascaded poles; the second one only counts when
                  // the strong filter is chosen, which doubles settling
                  d1 = $signed({pw[p][47], pw[p]})
                     - $signed({s_ff.pf1[p][47], s_ff.pf1[p]});
                  nxt_s.pf1[p] = 48'($signed(s_ff.pf1[p]) + (d1 >>> LPF_SHIFT));
                  d2 = $signed({nxt_s.pf1[p][47], nxt_s.pf1[p]})
                     - $signed({s_ff.pf2[p][47], s_ff.pf2[p]});
                  nxt_s.pf2[p] = 48'($signed(s_ff.pf2[p]) + (d2 >>> LPF_SHIFT));
                  pf = s_ff.power_filter_strength_select ? nxt_s.pf2[p] : nxt_s.pf1[p];
                  // full-scale in-phase power lands near 33,516,139 / 2^3
                  nxt_s.watt[p] = pf[`WATT_SHIFT +: 24];
               end
               if (delta) begin
                  nxt_s.pf1[1]  = 48'h0;
                  nxt_s.pf2[1]  = 48'h0;
                  nxt_s.watt[1] = 24'h000000;
               end
               nxt_s.ph  = 2'h0;
               nxt_s.seq = seq_root_e;
            end
         end
         seq_root_e: begin
            nxt_s.seq = seq_wait_e;
         end
         seq_wait_e: begin
            if (sq_done) begin
               nxt_s.rms[s_ff.ph] = root_sat;
               if (s_ff.ph == 2'h2) begin
                  nxt_s.upd = 1'b1;
                  nxt_s.seq = seq_idle_e;
                  for (int p = 0; p < 3; p++) begin
                     nxt_s.lacc[p] = s_ff.lacc[p]
                                   + (24+`LRIP_SHIFT)'(nxt_s.rms[p]);
                  end
                  if (s_ff.lcnt == AVG_LAST) begin
                     // whole period lands at once, then a fresh sum starts
                     for (int p = 0; p < 3; p++) begin
                        nxt_s.lrip[p] = nxt_s.lacc[p][AVG_LOG2 +: 24];
                        nxt_s.lacc[p] = '0;
                     end
                     nxt_s.lcnt = '0;
                  end else begin
                     nxt_s.lcnt = s_ff.lcnt + 1'b1;
                  end
               end else begin
                  nxt_s.ph  = s_ff.ph + 2'h1;
                  nxt_s.seq = seq_root_e;
               end
            end
         end
         default: nxt_s.seq = seq_idle_e;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_ff        <= '0;
         s_ff.seq    <= seq_idle_e;
         s_ff.wiring_config_select <= `ACCUMULATION_MODE_REGISTER_RST;
         s_ff.power_filter_strength_select <= `POWER_FILTER_STRENGTH_SELECT_RST;
         s_ff.offs   <= {3{`OFS_RST}};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // samples that arrive while the root sequence runs are dropped
   assign samp_ready       = (s_ff.seq == seq_idle_e);
   assign rms_update       = s_ff.upd;
   assign reg_rsp.rd_valid = s_ff.rd_valid;
   assign reg_rsp.rd_data  = s_ff.rd_data;

   ofs_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_req.wr_en && reg_req.addr == `REG_VOFS_A)
      |=> s_ff.offs[0] == $past(reg_req.wr_data[23:0]))
      else $error("offset write not stored");

   ofs_read_pad_a: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_req.rd_en && reg_req.addr == `REG_VOFS_B)
      |=> reg_rsp.rd_valid && reg_rsp.rd_data[31:28] == 4'h0
          && reg_rsp.rd_data[27:24] == {4{reg_rsp.rd_data[23]}}
          && reg_rsp.rd_data[23:0] == $past(s_ff.offs[1]))
      else $error("offset readback not sign extended");

   rms_read_pad_a: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_req.rd_en && reg_req.addr == `REG_VRMS_C)
      |=> reg_rsp.rd_data == {8'h00, $past(s_ff.rms[2])})
      else $error("rms readback not zero padded");

   delta_watt_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_ff.seq == seq_idle_e && samp_valid && delta)
      |=> s_ff.watt[1] == 24'h000000 && s_ff.seq == seq_root_e)
      else $error("phase b power not zero in delta");

   lrip_period_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_ff.lcnt == '0 && $past(s_ff.lcnt) != '0)
      |-> $past(s_ff.lcnt) == AVG_LAST && s_ff.lacc[0] == '0)
      else $error("average period length wrong");

   neg_rad_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_ff.seq == seq_root_e && rad_c[RW+1])
      |-> ##[1:30] (sq_done && sq_root == '0))
      else $error("negative compensated square not zero");

   rms_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_ff.seq == seq_idle_e && samp_valid) |-> ##[3:100] rms_update)
      else $error("rms results not refreshed after a sample");

   power_filter_strength_select_reset_a: assert property (@(posedge clk)
      $rose(rst_n) |-> s_ff.power_filter_strength_select == 1'b0)
      else $error("filter select not cleared by reset");

   avg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !avg_end
      |=> s_ff.lrip == $past(s_ff.lrip))
      else $error("average changed inside a period");

   avg_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      avg_end |=> s_ff.lcnt == '0 && s_ff.lacc[0] == '0
                  && s_ff.lacc[1] == '0 && s_ff.lacc[2] == '0)
      else $error("average sum not cleared at period end");

   avg_range_a: assert property (@(posedge clk) disable iff (!rst_n)
      !s_ff.lrip[0][23] && !s_ff.lrip[1][23]
      && !s_ff.lrip[2][23])
      else $error("average outside positive range");

   read_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rsp.rd_valid
      == $past(reg_req.rd_en))
      else $error("read valid not one cycle after read");

   read_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !reg_req.rd_en
      |=> reg_rsp.rd_data == $past(reg_rsp.rd_data))
      else $error("read data changed without a read");

   filter_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_req.wr_en && reg_req.addr == `REG_CONFIG)
      |=> s_ff.power_filter_strength_select == $past(reg_req.wr_data[`POWER_FILTER_STRENGTH_SELECT_BIT]))
      else $error("filter select write not stored");

   wiring_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_req.wr_en && reg_req.addr == `REG_ACCUMULATION_MODE_REGISTER)
      |=> s_ff.wiring_config_select == $past(reg_req.wr_data[`WIRING_CONFIG_SELECT_LSB +: 2]))
      else $error("wiring select write not stored");

   ofs_write_b_a: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_req.wr_en && reg_req.addr == `REG_VOFS_B)
      |=> s_ff.offs[1] == $past(reg_req.wr_data[23:0]))
      else $error("phase b offset write not stored");

   ofs_write_c_a: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_req.wr_en && reg_req.addr == `REG_VOFS_C)
      |=> s_ff.offs[2] == $past(reg_req.wr_data[23:0]))
      else $error("phase c offset write not stored");

   power_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !samp_take
      |=> s_ff.watt == $past(s_ff.watt))
      else $error("power changed without a sample");

   rms_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(s_ff.seq == seq_wait_e && sq_done)
      |=> s_ff.rms == $past(s_ff.rms))
      else $error("rms changed without a root");

   rms_range_a: assert property (@(posedge clk) disable iff (!rst_n)
      !s_ff.rms[0][23] && !s_ff.rms[1][23]
      && !s_ff.rms[2][23])
      else $error("rms outside positive range");

   ready_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
      samp_take
      |=> !samp_ready)
      else $error("ready stayed high after a sample");

   root_order_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_ff.seq == seq_wait_e && sq_done && s_ff.ph != 2'h2)
      |=> s_ff.seq == seq_root_e && s_ff.ph == $past(s_ff.ph) + 2'h1)
      else $error("phase roots out of order");

   update_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      rms_update
      |-> samp_ready && s_ff.ph == 2'h2)
      else $error("update pulse before the last root");
endmodule

/* tb/vrms_host_model.sv */
// host side model: word reads and writes on the decoded register port
// assumes one caller at a time and that clk is the dsp clock
`timescale 1ns/1ps
module vrms_host_model
   import vrms_power_pkg::*;
(
   input  wire logic     clk,
   output reg_req_t      reg_req,
   input  wire reg_rsp_t reg_rsp
);
   initial begin
      reg_req = '0;
   end

   // released lines flip so a stale address or data word never looks live
   task automatic release_bus();
      reg_req.wr_en   = 1'b0;
      reg_req.rd_en   = 1'b0;
      reg_req.addr    = ~reg_req.addr;
      reg_req.wr_data = ~reg_req.wr_data;
   endtask

   // offsets are only written as fixed values, never calibrated at zero input
   task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
      @(posedge clk);
      #1;
      reg_req.addr    = addr;
      reg_req.wr_data = data;
      reg_req.wr_en   = 1'b1;
      @(posedge clk);
      #1;
      release_bus();
   endtask

   // answer is registered, so it stands just after the edge that takes the read
   task automatic reg_read(input logic [7:0] addr, output logic [31:0] data,
                           output logic valid);
      @(posedge clk);
      #1;
      reg_req.addr  = addr;
      reg_req.rd_en = 1'b1;
      @(posedge clk);
      #1;
      data  = reg_rsp.rd_data;
      valid = reg_rsp.rd_valid;
      release_bus();
   endtask
endmodule

/* tb/voltage_rms_active_power_dsp_tb_top.sv */
// testbench top: resets the dsp, drives sample sets, checks registers via the host model
// assumes the dsp package and the host model are compiled first
`timescale 1ns/1ps
`include "vrms_power_regs.svh"
module voltage_rms_active_power_dsp_tb_top
   import vrms_power_pkg::*;
;
   logic        clk;
   logic        rst_n;
   logic        samp_valid;
   logic        samp_ready;
   logic        rms_update;
   logic        vld;
   sample_t     samp;
   reg_req_t    reg_req;
   reg_rsp_t    reg_rsp;
   int          bad_count = 0;
   int          check_count = 0;
   logic [31:0] rd;
   logic [31:0] weak_watt;
   logic [7:0]  rst_tab [15] = '{`REG_VAVG_A, `REG_VAVG_B, `REG_VAVG_C, `REG_VOFS_A,
      `REG_VOFS_B, `REG_VOFS_C, `REG_WATT_A, `REG_WATT_B, `REG_WATT_C, `REG_VRMS_A,
      `REG_VRMS_B, `REG_VRMS_C, `REG_ACCUMULATION_MODE_REGISTER, `REG_CONFIG, 8'h30};

   // short averaging period so that a whole period fits the run: eight rms sets
   voltage_rms_active_power_dsp #(
      .AVG_LOG2 (3)
   ) uut (
      .clk        (clk),
      .rst_n      (rst_n),
      .samp       (samp),
      .samp_valid (samp_valid),
      .samp_ready (samp_ready),
      .reg_req    (reg_req),
      .reg_rsp    (reg_rsp),
      .rms_update (rms_update)
   );

   vrms_host_model host (
      .clk     (clk),
      .reg_req (reg_req),
      .reg_rsp (reg_rsp)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check_eq(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // passes only when got is known and strictly above bound
   task automatic check_gt(input string name, input logic [31:0] bound,
                           input logic [31:0] got);
      check_count++;
      if (^got === 1'bx || got <= bound) begin
         bad_count++;
         $display("Error %s expected above %h seen %h", name, bound, got);
      end
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic v;
      host.reg_read(a, rd, v);
      check_eq({name, " valid"}, 32'h1, {31'h0, v});
      check_eq(name, exp, rd);
   endtask

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
   endtask

   // one sample set on all phases, then wait for the three roots to land
   task automatic send_sample(input logic [23:0] v, input logic [23:0] i);
      int n;
      @(posedge clk);
      #1;
      samp = {{3{v}}, {3{i}}};
      samp_valid = 1'b1;
      @(posedge clk);
      #1;
      samp_valid = 1'b0;
      samp = ~samp;
      n = 0;
      while (rms_update !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      check_eq("rms update", 32'h1, {31'h0, rms_update});
      @(posedge clk);
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      $display("Error watchdog expected done seen hang");
      report_and_stop();
   end

   initial begin
      rst_n = 1'b0;
      samp_valid = 1'b0;
      samp = '0;
      do_reset();
      foreach (rst_tab[k]) rd_chk("reset value", rst_tab[k], 32'h0);
      host.reg_write(`REG_WATT_A, 32'h00123456);
      host.reg_write(`REG_VAVG_A, 32'h00654321);
      rd_chk("ro power", `REG_WATT_A, 32'h0);
      rd_chk("ro average", `REG_VAVG_A, 32'h0);
      host.reg_write(`REG_VOFS_A, 32'h00000002);
      host.reg_write(`REG_VOFS_B, 32'h00000008);
      host.reg_write(`REG_VOFS_C, 32'hff800000);
      rd_chk("offset a", `REG_VOFS_A, 32'h00000002);
      rd_chk("offset c", `REG_VOFS_C, 32'h0f800000);
      // zero input: rms is purely the root of 128 times the offset
      send_sample(24'h0, 24'h0);
      rd_chk("rms a", `REG_VRMS_A, 32'h10);
      rd_chk("rms b", `REG_VRMS_B, 32'h20);
      rd_chk("rms c", `REG_VRMS_C, 32'h0);
      // delta with equal a and c: line voltage is zero, only the b offset remains
      host.reg_write(`REG_ACCUMULATION_MODE_REGISTER, 32'h1);
      rd_chk("wiring", `REG_ACCUMULATION_MODE_REGISTER, 32'h1);
      repeat (4) send_sample(24'h400000, 24'h400000);
      rd_chk("delta rms b", `REG_VRMS_B, 32'h20);
      rd_chk("delta power b", `REG_WATT_B, 32'h0);
      host.reg_read(`REG_VRMS_A, rd, vld);
      check_gt("rms a live", 32'h10, rd);
      host.reg_read(`REG_WATT_A, weak_watt, vld);
      check_gt("power a", 32'h0, weak_watt);
      check_gt("power a positive", weak_watt, 32'h007fffff);
      // same stimulus with the stronger filter must rise more slowly
      do_reset();
      // zero input with offsets gives known roots: a 16, c 64, each sample
      host.reg_write(`REG_VOFS_A, 32'h00000002);
      host.reg_write(`REG_VOFS_C, 32'h00000020);
      repeat (7) send_sample(24'h0, 24'h0);
      rd_chk("average early", `REG_VAVG_A, 32'h0);
      send_sample(24'h0, 24'h0);
      rd_chk("average a", `REG_VAVG_A, 32'h10);
      rd_chk("average c", `REG_VAVG_C, 32'h40);
      host.reg_write(`REG_CONFIG, 32'h2);
      rd_chk("filter select", `REG_CONFIG, 32'h2);
      repeat (4) send_sample(24'h400000, 24'h400000);
      host.reg_read(`REG_WATT_A, rd, vld);
      check_gt("slower filter", rd, weak_watt);
      report_and_stop();
   end
endmodule
